// ===== test/utc_line_model.sv
// partner: asynchronous line receiver sampling mid-bit
`timescale 1ns/10ps
module utc_line_model (
  input  wire logic        clk_sys,
  input  wire logic        line,
  input  wire logic        nine,
  input  wire logic [15:0] bt,
  output logic      [8:0]  rx_data,
  output int               rx_cnt
);
  initial rx_cnt = 0;
  always begin
    @(negedge line);
    rx_data = 9'h000;
    repeat (bt + bt / 2) @(posedge clk_sys);
    for (int i = 0; i < 8 + nine; i++) begin
      rx_data[i] = line;
      repeat (bt) @(posedge clk_sys);
    end
    rx_cnt++;
    // stop bit, or end of a break
    wait (line);
  end
endmodule

// ===== test/utc_top_chk.sv
// checker: port assertions of the transmit control block
`timescale 1ns/10ps
module utc_top_chk
  import utc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_out,
  input wire logic        sclk_oe,
  input wire logic        irq
);
  logic [7:0]  tsc_q;
  logic [15:0] baud_q;
  logic [2:0]  msk_q;
  int          low_q;
  int          bt;
  logic        wr;
  assign wr = psel && penable && pwrite;
  assign bt = (baud_q + 1) * (tsc_q[UTC_B_SPEED] ? 4 : 16);
  // shadow of written control words, and length of the current low run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tsc_q <= 8'h00;
      baud_q <= 16'h0000;
      msk_q <= 3'h0;
      low_q <= 0;
    end else begin
      if (wr && paddr == UTC_OFF_TSC) tsc_q <= pwdata[7:0];
      if (wr && paddr == UTC_OFF_BAUD) baud_q <= pwdata[15:0];
      if (wr && paddr == UTC_OFF_MASK) msk_q <= pwdata[2:0];
      low_q <= tx_out ? 0 : low_q + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  apb_ready_a: assert property (pready == (psel && penable)) else $error("pready wrong");
  bad_addr_a: assert property (psel && penable && paddr > UTC_OFF_BAUD |-> pslverr)
    else $error("no pslverr");
  read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved");
  tx_gate_a: assert property (!tsc_q[5] && !$past(tsc_q[5]) |-> tx_out)
    else $error("tx active while disabled");
  clk_drive_a: assert property (sclk_oe == (tsc_q[7] && tsc_q[4] && tsc_q[5]))
    else $error("sclk_oe wrong");
  bit_time_a: assert property ($rose(tx_out) && tsc_q[5] && !tsc_q[4] |-> low_q % bt == 0)
    else $error("bit time wrong");
  irq_mask_a: assert property (msk_q == 3'h0 |-> !irq) else $error("masked irq");
  reset_idle_a: assert property ($past(rst) |-> tx_out && !irq && !sclk_oe)
    else $error("not idle after reset");
  cover property ($rose(tx_out) && !tsc_q[4]);
  cover property (sclk_oe);
  cover property (irq);
endmodule
bind utc_top utc_top_chk utc_top_chk_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .sclk_oe(sclk_oe), .irq(irq));

// ===== test/utc_top_test.sv
// testbench: apb stimulus and line checks of the transmit control block
`timescale 1ns/10ps
module utc_top_test;
  import utc_pkg::*;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sclk_in = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, tx_out, sclk_out, sclk_oe, irq, nine = 0, lv;
  logic [8:0]  rx_data, e9;
  logic [15:0] bt = 16'h0010;
  int          err_count = 0, check_count = 0, cyc = 0, seed = 16106, cnt, n, b;
  always #5 clk_sys = ~clk_sys;
  utc_top utc_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_in(sclk_in), .tx_out(tx_out), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .irq(irq));
  utc_line_model utc_line_model_inst (.clk_sys(clk_sys), .line(tx_out), .nine(nine),
    .bt(bt), .rx_data(rx_data), .rx_cnt(cnt));
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      finish_test;
    end
  end
  // clocks per async bit: divisor plus one, times the ticks of the speed range
  function automatic logic [15:0] bit_clocks(input int div, input logic hi);
    bit_clocks = 16'((div + 1) * (hi ? UTC_TICKS_HI : UTC_TICKS_LO));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    @(negedge clk_sys);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    // let outputs launched by this edge settle before the caller samples them
    @(negedge clk_sys);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    apb(0, UTC_OFF_TSC, 0);
    chk(rd, {24'h0, UTC_TSC_RST});
    apb(1, UTC_OFF_TSC, 32'h0000_0040);
    apb(0, UTC_OFF_TSC, 0);
    chk(rd, 32'h0000_0042);
    apb(0, 8'h14, 0);
    chk(rd, 0);
    $display("test registers done");
    apb(1, UTC_OFF_MASK, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      b = $unsigned($random(seed)) % 3;
      e9 = 9'($random(seed));
      nine = k[0];
      bt = bit_clocks(b, k[1]);
      apb(1, UTC_OFF_BAUD, b);
      apb(1, UTC_OFF_TSC, {24'h0, 1'b0, k[0], 3'b100, k[1], 1'b0, e9[8]});
      n = cnt;
      apb(1, UTC_OFF_DATA, {24'h0, e9[7:0]});
      repeat (4) @(posedge clk_sys);
      apb(0, UTC_OFF_TSC, 0);
      chk(rd[1], 0);
      while (cnt == n) @(posedge clk_sys);
      chk(rx_data, {e9[8] & k[0], e9[7:0]});
      repeat (bt + 8) @(posedge clk_sys);
      apb(0, UTC_OFF_TSC, 0);
      chk(rd[1], 1);
    end
    chk(irq, 1);
    apb(0, UTC_OFF_STAT, 0);
    chk(rd[2:0], 3'h5);
    apb(1, UTC_OFF_STAT, 32'h0000_0007);
    chk(irq, 0);
    $display("test async frames done");
    apb(1, UTC_OFF_MASK, 0);
    nine = 0;
    bt = bit_clocks(b, 1'b0);
    apb(1, UTC_OFF_TSC, 32'h0000_0028);
    n = cnt;
    apb(1, UTC_OFF_DATA, 32'h0000_00FF);
    while (cnt == n) @(posedge clk_sys);
    chk(rx_data, 0);
    repeat (13 * bt) @(posedge clk_sys);
    apb(0, UTC_OFF_TSC, 0);
    chk(rd, 32'h0000_0022);
    apb(1, UTC_OFF_MASK, 32'h0000_0002);
    chk(irq, 1);
    $display("test break done");
    for (int k = 0; k < 2; k++) begin
      apb(1, UTC_OFF_TSC, {24'h0, 5'b10110, k[0], 2'b00});
      chk(sclk_oe, 1);
      apb(1, UTC_OFF_DATA, 32'h0000_005A);
      lv = sclk_out;
      while (sclk_out === lv) @(negedge clk_sys);
      lv = sclk_out;
      n = 0;
      @(negedge clk_sys);
      while (sclk_out === lv) begin
        n++;
        @(negedge clk_sys);
      end
      chk(n, b);
      repeat (40 * bt) @(posedge clk_sys);
    end
    // synchronous slave: the line partner clocks each bit out on a falling edge
    apb(1, UTC_OFF_TSC, 32'h0000_0030);
    apb(1, UTC_OFF_DATA, 32'h0000_00A5);
    for (int i = 0; i < 8; i++) begin
      repeat (8) @(posedge clk_sys);
      sclk_in <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(tx_out, 32'((8'hA5 >> i) & 8'h01));
      @(posedge clk_sys);
      sclk_in <= 1'b0;
    end
    repeat (16) @(posedge clk_sys);
    apb(1, UTC_OFF_TSC, 32'h0000_00A0);
    chk(sclk_oe, 0);
    apb(1, UTC_OFF_TSC, 0);
    apb(1, UTC_OFF_DATA, 32'h0000_0000);
    repeat (20) @(posedge clk_sys);
    chk(tx_out, 1);
    $display("test sync and disable done");
    finish_test;
  end
endmodule

// ===== verilog/utc_cfg_if.sv
// interface: configuration from register file to shifter
`timescale 1ns/10ps
interface utc_cfg_if;
  logic        tx_en;
  logic        sync_mode;
  logic        speed_hi;
  logic        nine_bit;
  logic        clk_master;
  logic [15:0] baud_div;
  logic        load;
  logic [8:0]  load_data;
  logic        brk_req;
  logic        busy;
  logic        done;
  logic        brk_done;
  modport regs (output tx_en, sync_mode, speed_hi, nine_bit, clk_master, baud_div,
                output load, load_data, brk_req, input busy, done, brk_done);
  modport shft (input tx_en, sync_mode, speed_hi, nine_bit, clk_master, baud_div,
                input load, load_data, brk_req, output busy, done, brk_done);
endinterface

// ===== verilog/utc_pkg.sv
// package: register map, field positions and constants of the transmit control block
package utc_pkg;
  localparam logic [7:0] UTC_ADDR_W = 8'h08;
  // register byte addresses
  localparam logic [7:0] UTC_OFF_TSC   = 8'h00;
  localparam logic [7:0] UTC_OFF_DATA  = 8'h04;
  localparam logic [7:0] UTC_OFF_STAT  = 8'h08;
  localparam logic [7:0] UTC_OFF_MASK  = 8'h0C;
  localparam logic [7:0] UTC_OFF_BAUD  = 8'h10;
  // transmit_status_control bit positions
  localparam int UTC_B_NINTH = 0;
  localparam int UTC_B_EMPTY = 1;
  localparam int UTC_B_SPEED = 2;
  localparam int UTC_B_BRK   = 3;
  localparam int UTC_B_SYNC  = 4;
  localparam int UTC_B_TRANSMITTER_ENABLE  = 5;
  localparam int UTC_B_NINE  = 6;
  localparam int UTC_B_CLOCK_SOURCE_MASTER_SELECT  = 7;
  // reset values
  localparam logic [7:0]  UTC_TSC_RST  = 8'h02;
  localparam logic [15:0] UTC_BAUD_RST = 16'h0000;
  // interrupt status bits
  localparam int UTC_I_DONE = 0;
  localparam int UTC_I_BRK  = 1;
  localparam int UTC_I_LOAD = 2;
  localparam int UTC_NIRQ   = 3;
  // low speed range divides each bit into 16 ticks, high speed into 4
  localparam logic [4:0] UTC_TICKS_LO = 5'h10;
  localparam logic [4:0] UTC_TICKS_HI = 5'h04;
  // break frame is start plus 12 low bits
  localparam logic [3:0] UTC_BRK_BITS = 4'hC;
  typedef enum logic [3:0] {
    UTC_IDLE  = 4'b0001,
    UTC_START = 4'b0010,
    UTC_DATA  = 4'b0100,
    UTC_STOP  = 4'b1000
  } utc_state_t;
endpackage

// ===== verilog/utc_shifter.sv
// transmit shifter: frames bytes or breaks onto the serial pins
`timescale 1ns/10ps
module utc_shifter
  import utc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic sclk_in,
  utc_cfg_if.shft   cfg,
  output logic      tx_out,
  output logic      sclk_out,
  output logic      sclk_oe
);
  typedef struct packed {
    utc_state_t st;
    logic [9:0] sh;
    logic [3:0] cnt;
    logic [15:0] div;
    logic [4:0] tick;
    logic       brk;
    logic       tx;
    logic       sck;
    logic       s1;
    logic       s2;
    logic       s3;
    logic       done;
    logic       bdone;
  } utc_shft_t;
  utc_shft_t q, d;
  logic bit_end;
  logic ext_fall;
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.bdone = 1'b0;
    d.s1 = sclk_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    ext_fall = q.s3 & ~q.s2;
    bit_end = 1'b0;
    if (q.st != UTC_IDLE) begin
      if (cfg.sync_mode && !cfg.clk_master) begin
        bit_end = ext_fall;
      end else if (q.div == cfg.baud_div) begin
        d.div = 16'h0000;
        if (cfg.sync_mode) begin
          d.sck = ~q.sck;
          bit_end = q.sck;
        end else begin
          d.tick = q.tick + 5'h01;
          if (q.tick == (cfg.speed_hi ? UTC_TICKS_HI : UTC_TICKS_LO) - 5'h01) begin
            d.tick = 5'h00;
            bit_end = 1'b1;
          end
        end
      end else begin
        d.div = q.div + 16'h0001;
      end
    end
    case (q.st)
      UTC_IDLE: begin
        d.tx = 1'b1;
        d.sck = 1'b0;
        if (cfg.load && cfg.tx_en) begin
          d.sh = {1'b1, cfg.load_data};
          d.brk = cfg.brk_req & ~cfg.sync_mode;
          d.div = 16'h0000;
          d.tick = 5'h00;
          d.st = cfg.sync_mode ? UTC_DATA : UTC_START;
          d.cnt = cfg.nine_bit ? 4'h9 : 4'h8;
          if (cfg.sync_mode) begin
            d.tx = cfg.load_data[0];
            d.sh = {2'b11, cfg.load_data[8:1]};
          end else begin
            d.tx = 1'b0;
          end
          if (d.brk) d.cnt = UTC_BRK_BITS;
        end
      end
      UTC_START: if (bit_end) begin
        d.st = UTC_DATA;
        d.tx = q.brk ? 1'b0 : q.sh[0];
        d.sh = {1'b1, q.sh[9:1]};
        d.cnt = q.cnt - 4'h1;
      end
      UTC_DATA: if (bit_end) begin
        if (q.cnt == 4'h0 || (cfg.sync_mode && q.cnt == 4'h1)) begin
          d.st = cfg.sync_mode ? UTC_IDLE : UTC_STOP;
          d.tx = 1'b1;
          d.done = cfg.sync_mode;
        end else begin
          d.tx = q.brk ? 1'b0 : q.sh[0];
          d.sh = {1'b1, q.sh[9:1]};
          d.cnt = q.cnt - 4'h1;
        end
      end
      UTC_STOP: if (bit_end) begin
        d.st = UTC_IDLE;
        d.done = 1'b1;
        d.bdone = q.brk;
        d.brk = 1'b0;
      end
      default: d.st = UTC_IDLE;
    endcase
    if (!cfg.tx_en) begin
      d.st = UTC_IDLE;
      d.tx = 1'b1;
      d.brk = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{st: UTC_IDLE, tx: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end
  assign tx_out   = q.tx;
  assign sclk_out = q.sck;
  assign sclk_oe  = cfg.sync_mode & cfg.clk_master & cfg.tx_en;
  assign cfg.busy = (q.st != UTC_IDLE);
  assign cfg.done = q.done;
  assign cfg.brk_done = q.bdone;
endmodule

// ===== verilog/utc_top.sv
// apb register file of the transmit status and control block
`timescale 1ns/10ps
module utc_top
  import utc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk_in,
  output logic             tx_out,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  tsc;
    logic [15:0] baud;
    logic [UTC_NIRQ-1:0] stat;
    logic [UTC_NIRQ-1:0] mask;
    logic [8:0]  hold;
    logic        full;
    logic [31:0] rdata;
    logic        s1;
    logic        s2;
  } utc_regs_t;
  utc_regs_t q, d;
  utc_cfg_if cfg ();
  logic wr;
  logic rd;
  logic acc;
  logic [UTC_NIRQ-1:0] ev;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == UTC_OFF_TSC) || (a == UTC_OFF_DATA) || (a == UTC_OFF_STAT) ||
             (a == UTC_OFF_MASK) || (a == UTC_OFF_BAUD);
  endfunction
  assign acc = psel & penable;
  assign wr  = acc & pwrite & mapped(paddr);
  assign rd  = psel & ~penable & ~pwrite;
  always_comb begin
    d = q;
    d.s1 = sclk_in;
    d.s2 = q.s1;
    ev = '0;
    ev[UTC_I_DONE] = cfg.done;
    ev[UTC_I_BRK]  = cfg.brk_done;
    ev[UTC_I_LOAD] = q.full & ~cfg.busy & q.tsc[UTC_B_TRANSMITTER_ENABLE];
    if (ev[UTC_I_LOAD]) d.full = 1'b0;
    if (cfg.brk_done) d.tsc[UTC_B_BRK] = 1'b0;
    if (wr) begin
      if (paddr == UTC_OFF_TSC) begin
        d.tsc = {pwdata[7:2], q.tsc[UTC_B_EMPTY], pwdata[0]};
      end else if (paddr == UTC_OFF_DATA) begin
        d.hold = {q.tsc[UTC_B_NINTH], pwdata[7:0]};
        d.full = 1'b1;
      end else if (paddr == UTC_OFF_STAT) begin
        d.stat = q.stat & ~pwdata[UTC_NIRQ-1:0];
      end else if (paddr == UTC_OFF_MASK) begin
        d.mask = pwdata[UTC_NIRQ-1:0];
      end else begin
        d.baud = pwdata[15:0];
      end
    end
    d.stat = d.stat | ev;
    d.tsc[UTC_B_EMPTY] = ~cfg.busy & ~(ev[UTC_I_LOAD]);
    if (rd) begin
      if (paddr == UTC_OFF_TSC) begin
        d.rdata = {24'h00_0000, q.tsc};
      end else if (paddr == UTC_OFF_DATA) begin
        d.rdata = {23'h00_0000, q.hold};
      end else if (paddr == UTC_OFF_STAT) begin
        d.rdata = {29'h0000_0000, q.stat};
      end else if (paddr == UTC_OFF_MASK) begin
        d.rdata = {29'h0000_0000, q.mask};
      end else if (paddr == UTC_OFF_BAUD) begin
        d.rdata = {16'h0000, q.baud};
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.tsc <= UTC_TSC_RST;
      q.baud <= UTC_BAUD_RST;
    end else begin
      q <= d;
    end
  end
  assign cfg.tx_en      = q.tsc[UTC_B_TRANSMITTER_ENABLE];
  assign cfg.sync_mode  = q.tsc[UTC_B_SYNC];
  assign cfg.speed_hi   = q.tsc[UTC_B_SPEED];
  assign cfg.nine_bit   = q.tsc[UTC_B_NINE];
  assign cfg.clk_master = q.tsc[UTC_B_CLOCK_SOURCE_MASTER_SELECT] & q.tsc[UTC_B_SYNC];
  assign cfg.baud_div   = q.baud;
  assign cfg.load       = ev[UTC_I_LOAD];
  assign cfg.load_data  = q.hold;
  assign cfg.brk_req    = q.tsc[UTC_B_BRK];
  utc_shifter u_shft (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .sclk_in  (q.s2),
    .cfg      (cfg.shft),
    .tx_out   (tx_out),
    .sclk_out (sclk_out),
    .sclk_oe  (sclk_oe)
  );
  assign prdata  = q.rdata;
  assign pready  = acc;
  assign pslverr = acc & ~mapped(paddr);
  assign irq     = |(q.stat & q.mask);
endmodule
